// ### oms_board.sv
// Board model: strap resistors, chip-select tie and free-running crystal source
`timescale 1ns/10ps
module oms_board (
    input  wire logic       core_clk,
    input  wire logic [3:0] strap_req,
    input  wire logic       cs_req_n,
    input  wire logic       pin_drive,
    input  wire logic       pin_drive_oe,
    output logic            supply_watch_select,
    output logic            factory_probe_pin,
    output logic            repeater_or_handset_select,
    output logic            pulse_ring_mode_pin_in,
    output logic            crystal_input,
    output logic            spi_chip_select_n
);
    logic [1:0] xdiv_r = 2'h0;
    logic       xtal_r = 1'h0;
    // Strap request word is {watch, probe, select, pin}
    assign supply_watch_select        = strap_req[3];
    assign factory_probe_pin          = strap_req[2];
    assign repeater_or_handset_select = strap_req[1];
    // Shared pin: device wins while it drives, strap resistor otherwise
    assign pulse_ring_mode_pin_in     = pin_drive_oe ? pin_drive : strap_req[0];
    // Relay boards tie chip select inactive
    assign spi_chip_select_n = (strap_req[1] && !strap_req[0]) ? 1'h1 : cs_req_n;
    assign crystal_input     = xtal_r;
    // Crystal runs through reset; 8 core periods so the synchroniser sees every edge
    always @(posedge core_clk)
    begin
        xdiv_r <= xdiv_r + 2'h1;
        if (xdiv_r == 2'h3)
            xtal_r <= ~xtal_r;
    end
endmodule

// ### oms_decode.sv
// Module: combinational decoder from synchronised straps to configuration
`timescale 1ns/10ps
module oms_decode (
    input  wire oms_pkg::oms_straps_t straps,
    output oms_pkg::oms_cfg_t         cfg
);

    // -----------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------
    always_comb
    begin
        cfg      = '0;
        cfg.mode = oms_pkg::oms_decode_mode(straps.repeater_or_handset_select,
                                            straps.pulse_ring_mode_in);
        case (cfg.mode)
            oms_pkg::OMS_HANDSET:
            begin
                cfg.pulse_pin_drive    = 1'b1;
                cfg.clock_out_drive    = 1'b1;
                cfg.line_if_active     = 1'b1;
                cfg.supply_detect_en   = (straps.supply_watch_select == oms_pkg::STRAP_LOW);
                cfg.ext_reset_required = (straps.supply_watch_select == oms_pkg::STRAP_HIGH);
                cfg.strobe_en          = 1'b1;
            end
            oms_pkg::OMS_RELAY:
            begin
                cfg.line_if_active     = 1'b1;
                cfg.side_channel_en    = 1'b1;
                cfg.side_bit_const_one = (straps.supply_watch_select == oms_pkg::STRAP_HIGH);
            end
            oms_pkg::OMS_FRAMER:
            begin
                cfg.line_if_active     = 1'b0;
                cfg.supply_detect_en   = (straps.supply_watch_select == oms_pkg::STRAP_LOW);
                cfg.ext_reset_required = (straps.supply_watch_select == oms_pkg::STRAP_HIGH);
                cfg.strobe_en          = 1'b1;
            end
            default:
            begin
                cfg.line_if_active = 1'b0;
            end
        endcase
        // Test register reachable only while the probe pin is low
        cfg.test_reg_allowed = (straps.factory_probe_pin == oms_pkg::STRAP_LOW);
    end

endmodule

// ### oms_pkg.sv
// Package: shared types and constants for the operating mode strap select block
package oms_pkg;

    // Operating modes decoded from the straps
    typedef enum logic [1:0] {
        OMS_HANDSET,
        OMS_RELAY,
        OMS_FRAMER
    } oms_mode_t;

    // Strap levels
    localparam logic STRAP_LOW  = 1'b0;
    localparam logic STRAP_HIGH = 1'b1;

    // Crystal periods that must follow reset in framing-controller mode
    localparam int unsigned XTAL_POST_RESET_PERIODS = 80;
    localparam int unsigned XCNT_W = 7;
    localparam logic [6:0] XCNT_ZERO = 7'h00;
    localparam logic [6:0] XCNT_ONE  = 7'h01;

    // Synchroniser depth
    localparam int unsigned SYNC_DEPTH = 3;

    // Raw strap bundle after synchronisation
    typedef struct packed {
        logic supply_watch_select;
        logic factory_probe_pin;
        logic repeater_or_handset_select;
        logic pulse_ring_mode_in;
        logic crystal_input;
    } oms_straps_t;

    localparam oms_straps_t STRAPS_RESET = '{
        supply_watch_select:        1'b1,
        factory_probe_pin:          1'b1,
        repeater_or_handset_select: 1'b0,
        pulse_ring_mode_in:         1'b0,
        crystal_input:              1'b0
    };

    // Decoded configuration bundle
    typedef struct packed {
        oms_mode_t mode;
        logic      supply_detect_en;
        logic      ext_reset_required;
        logic      test_reg_allowed;
        logic      side_bit_const_one;
        logic      pulse_pin_drive;
        logic      line_if_active;
        logic      clock_out_drive;
        logic      side_channel_en;
        logic      strobe_en;
    } oms_cfg_t;

    localparam int unsigned STRAP_W = $bits(oms_straps_t);

    // Mode decode, used by the decoder only; the top takes the mode from cfg
    function automatic oms_mode_t oms_decode_mode(input logic rt_sel, input logic pin_lvl);
        oms_mode_t m;
        m = OMS_HANDSET;
        if (rt_sel == STRAP_HIGH)
        begin
            m = (pin_lvl == STRAP_HIGH) ? OMS_FRAMER : OMS_RELAY;
        end
        return m;
    endfunction

endpackage

// ### oms_properties.sv
// Checker: concurrent properties on the mode strap select outputs
`timescale 1ns/10ps
module oms_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pulse_ring_value,
    input wire logic strobe_slot,
    input wire logic local_data_clock,
    input wire logic stop_go_bit,
    input wire logic bus_request,
    input wire logic bus_free,
    input wire logic pulse_ring_mode_pin_out,
    input wire logic pulse_ring_mode_pin_oe,
    input wire logic backplane_data_clock_out,
    input wire logic backplane_data_clock_oe,
    input wire logic handset_mode,
    input wire logic relay_station_mode,
    input wire logic framer_mode,
    input wire logic supply_detect_en,
    input wire logic ext_reset_required,
    input wire logic side_channel_bit,
    input wire logic line_if_enable,
    input wire logic shared_access_bus_grant,
    input wire logic serial_strobe,
    input wire logic framer_reset_done
);
    // ----------------------------------------
    // Settle counter
    // ----------------------------------------
    // Outputs hold reset values for the first edges, so $past looks are gated
    logic [1:0] live_r;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            live_r <= 2'h0;
        else if (live_r != 2'h3)
            live_r <= live_r + 2'h1;
    end
    wire ok = (live_r == 2'h3);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_mode_onehot: assert property (ok |-> $onehot0({handset_mode, relay_station_mode, framer_mode}))
        else $error("more than one mode flag set");
    chk_pin_drive: assert property (ok && handset_mode && $past(handset_mode) |-> pulse_ring_mode_pin_oe &&
        pulse_ring_mode_pin_out == $past(pulse_ring_value)) else $error("shared pin not driving in handset mode");
    chk_pin_input: assert property (ok && !handset_mode && $past(!handset_mode) |->
        !pulse_ring_mode_pin_oe && !backplane_data_clock_oe) else $error("pin driven outside handset mode");
    chk_clock_out: assert property (ok && handset_mode && $past(handset_mode) |-> backplane_data_clock_oe &&
        backplane_data_clock_out == $past(local_data_clock)) else $error("data clock not driven in handset");
    chk_supply_pick: assert property (ok && !relay_station_mode && $past(!relay_station_mode) |->
        supply_detect_en != ext_reset_required) else $error("supply detect and external reset both or neither");
    chk_side_bit: assert property (ok && relay_station_mode && $past(relay_station_mode) && !side_channel_bit |->
        !$past(stop_go_bit)) else $error("side bit low without stop/go low");
    chk_line_off: assert property (ok && framer_mode && $past(framer_mode) |-> !line_if_enable)
        else $error("line interface active in framer mode");
    chk_grant_cause: assert property (ok && shared_access_bus_grant |-> $past(bus_request) &&
        $past(bus_free) && !$past(handset_mode)) else $error("grant without request and free bus");
    chk_strobe_follow: assert property (ok && !relay_station_mode && $past(!relay_station_mode) |->
        serial_strobe == $past(strobe_slot)) else $error("strobe does not follow slot");
    chk_done_mode: assert property (ok && framer_reset_done |-> $past(framer_mode))
        else $error("reset done outside framer mode");
    chk_done_late: assert property (ok && $rose(framer_mode) |-> !framer_reset_done [*8])
        else $error("reset done too early");

    cover_relay: cover property (ok && relay_station_mode);
    cover_done: cover property ($rose(framer_reset_done));
    cover_grant: cover property (shared_access_bus_grant);
endmodule

bind oms_top oms_properties u_oms_chk (.core_clk, .rst, .pulse_ring_value, .strobe_slot, .local_data_clock,
    .stop_go_bit, .bus_request, .bus_free, .pulse_ring_mode_pin_out, .pulse_ring_mode_pin_oe,
    .backplane_data_clock_out, .backplane_data_clock_oe, .handset_mode, .relay_station_mode, .framer_mode,
    .supply_detect_en, .ext_reset_required, .side_channel_bit, .line_if_enable, .shared_access_bus_grant,
    .serial_strobe, .framer_reset_done);

// ### oms_sync.sv
// Module: three-stage synchroniser bank for strap and clock pins
`timescale 1ns/10ps
module oms_sync #(
    parameter int unsigned WIDTH = 5
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } oms_sync_state_t;

    oms_sync_state_t st_r;
    oms_sync_state_t st_nxt;
    logic            loaded_r;

    // -----------------------------------------------------------------
    // Shift and agree
    // -----------------------------------------------------------------
    // Stage one feeds only stage two; the output moves when stages two and three agree
    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st_r.s2[i] == st_r.s3[i])
            begin
                st_nxt.q[i] = st_r.s3[i];
            end
        end
        // First clock after reset primes all stages, so cleared stages never leak zeros
        if (!loaded_r)
        begin
            st_nxt.s1 = reset_val;
            st_nxt.s2 = reset_val;
            st_nxt.s3 = reset_val;
            st_nxt.q  = reset_val;
        end
    end

    // Reset takes constants only; the idle levels come from the priming clock
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_r     <= '0;
            loaded_r <= 1'b0;
        end
        else
        begin
            st_r     <= st_nxt;
            loaded_r <= 1'b1;
        end
    end

    // Idle levels are shown until the bank is primed
    assign sync_out = loaded_r ? st_r.q : reset_val;

endmodule

// ### oms_top.sv
// Module: operating mode strap select top, registered configuration outputs
`timescale 1ns/10ps

// -----------------------------------------------------------------
// Overview
// -----------------------------------------------------------------
// Board straps pick one of three operating modes
// Handset: select strap low, shared pin is an output
// Relay: select strap high, shared pin strapped low
// Framer: select strap high, shared pin strapped high
// The decoded mode sets every direction enable below
// No register bus: all controls and status are plain pins
//
// Pin straps pass a three-stage synchroniser bank
// A strap level counts once stages two and three agree
// Glitches shorter than two samples never reach the mode
// Until the bank is primed it shows the idle strap levels
//
// Same-clock inputs are gated without synchronisation
// They reach the outputs one clock after they are sampled
// Strap changes reach the outputs about five clocks later
//
// Every output is a register bit of one state struct
// Reset clears the struct, so all pins start undriven
// The first clock after reset loads the idle strap decode
//
// Output summary
// Shared pin out and enable: pulse value in handset mode
// Data clock out and enable: local clock in handset mode
// Mode flags: one-hot handset, relay or framer
// Supply detect: watch strap low in handset or framer mode
// External reset: watch strap high in handset or framer mode
// Test register enable: probe pin low
// Side-channel bit: stop/go or one in relay, one elsewhere
// Line enable: high except in framer mode
// Bus grant: relay or framer, with request and free bus
// Strobe: slot input in handset or framer mode
// Serial enable: chip select low outside relay mode
// Reset done: eighty crystal edges seen in framer mode
//
// Limitations
// Straps are static; changing them live is unsupported
// A strap change may show a passing wrong mode for a few clocks
// Edge counting needs a crystal slower than a quarter clock
// Faster crystals lose edges in the synchroniser
// The count stops at its target, so the flag cannot wrap
//
// Trade-offs
// Mode flags cost three flops but keep every output registered
// The grant uses last cycle's mode flags, not the new ones
// So a grant may outlast a mode change by one clock

// How it works
// - Watch select low: supply detect, own resets
// - Watch select high: detect off, external reset
// - Relay mode: watch select picks stop/go or one
// - Probe pin gates test register selection
// - Select low: handset mode, pulse pin output
// - Select high: pin low relay, high framer
// - Framer: line interface off, shared bus only
// - Relay: side channel plus shared bus control
// - Drive strobe marking codec time slot
// - Upstream arbitration uses shared bus procedure
// - Handset drives data clock, others accept it
module oms_top (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Strap and crystal pins, synchronised here
    input  wire logic supply_watch_select,
    input  wire logic factory_probe_pin,
    input  wire logic repeater_or_handset_select,
    input  wire logic pulse_ring_mode_pin_in,
    input  wire logic crystal_input,
    // Same-clock inputs from neighbouring logic
    input  wire logic stop_go_bit,
    input  wire logic pulse_ring_value,
    input  wire logic strobe_slot,
    input  wire logic local_data_clock,
    input  wire logic spi_chip_select_n,
    input  wire logic bus_request,
    input  wire logic bus_free,
    // Shared pin and data clock drivers
    output logic      pulse_ring_mode_pin_out,
    output logic      pulse_ring_mode_pin_oe,
    output logic      backplane_data_clock_out,
    output logic      backplane_data_clock_oe,
    // Decoded mode and configuration levels
    output logic      handset_mode,
    output logic      relay_station_mode,
    output logic      framer_mode,
    output logic      supply_detect_en,
    output logic      ext_reset_required,
    output logic      test_reg_select_en,
    output logic      side_channel_bit,
    output logic      line_if_enable,
    // Gated same-clock results and framer status
    output logic      shared_access_bus_grant,
    output logic      serial_strobe,
    output logic      spi_enable,
    output logic      framer_reset_done
);

    // -----------------------------------------------------------------
    // Synchronise the pins
    // -----------------------------------------------------------------
    oms_pkg::oms_straps_t raw_straps;
    oms_pkg::oms_straps_t sync_straps;
    oms_pkg::oms_cfg_t    cfg;

    // One bundle so all pins share one synchroniser bank
    assign raw_straps = '{
        supply_watch_select:        supply_watch_select,
        factory_probe_pin:          factory_probe_pin,
        repeater_or_handset_select: repeater_or_handset_select,
        pulse_ring_mode_in:         pulse_ring_mode_pin_in,
        crystal_input:              crystal_input
    };

    // Reset value gives the idle straps until the bank is primed
    oms_sync #(
        .WIDTH     (oms_pkg::STRAP_W)
    ) u_sync (
        .core_clk  (core_clk),
        .rst       (rst),
        .async_in  (raw_straps),
        .reset_val (oms_pkg::STRAPS_RESET),
        .sync_out  (sync_straps)
    );

    // Pure decode; its result is registered below
    oms_decode u_decode (
        .straps (sync_straps),
        .cfg    (cfg)
    );

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    // One packed struct holds all state of this module
    typedef struct packed {
        logic                            pr_out;
        logic                            pr_oe;
        logic                            dcl_out;
        logic                            dcl_oe;
        logic                            m_handset;
        logic                            m_relay;
        logic                            m_framer;
        logic                            sup_en;
        logic                            ext_rst;
        logic                            test_en;
        logic                            side_bit;
        logic                            line_en;
        logic                            grant;
        logic                            strobe;
        logic                            spi_en;
        logic                            xtal_prev;
        logic [oms_pkg::XCNT_W-1:0]      xtal_cnt;
        logic                            xdone;
    } oms_state_t;

    // Crystal rising edges needed before the framer counts as reset
    localparam logic [oms_pkg::XCNT_W-1:0] XTAL_TARGET = oms_pkg::XCNT_W'(oms_pkg::XTAL_POST_RESET_PERIODS);

    // Registered copy and next copy of the state
    oms_state_t st_r;
    oms_state_t st_nxt;

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    // Same-clock inputs are used directly; only pins pass the synchroniser
    always_comb
    begin
        st_nxt = st_r;

        // Mode flags follow the decoded straps every cycle
        // Exactly one flag is high once the bank is primed
        st_nxt.m_handset = (cfg.mode == oms_pkg::OMS_HANDSET);
        st_nxt.m_relay   = (cfg.mode == oms_pkg::OMS_RELAY);
        st_nxt.m_framer  = (cfg.mode == oms_pkg::OMS_FRAMER);

        // Shared pin: output in handset mode, input otherwise
        // Idle low so a released pin carries no stale pulse
        st_nxt.pr_oe  = cfg.pulse_pin_drive;
        st_nxt.pr_out = cfg.pulse_pin_drive ? pulse_ring_value : 1'b0;

        // Data clock direction
        // Accepted as an input in relay and framer modes
        st_nxt.dcl_oe  = cfg.clock_out_drive;
        st_nxt.dcl_out = cfg.clock_out_drive ? local_data_clock : 1'b0;

        // Reset source selection
        // Relay mode leaves both low; its shared strap means something else
        st_nxt.sup_en  = cfg.supply_detect_en;
        st_nxt.ext_rst = cfg.ext_reset_required;

        // Test register gate
        // Probe high keeps the test register out of reach
        st_nxt.test_en = cfg.test_reg_allowed;

        // Side-channel bit: constant one or stop/go
        // One outside relay mode, the idle level of the side channel
        if (cfg.side_channel_en)
        begin
            st_nxt.side_bit = cfg.side_bit_const_one ? 1'b1 : stop_go_bit;
        end
        else
        begin
            st_nxt.side_bit = 1'b1;
        end

        // Line interface held inactive in framer mode
        // The framer reaches the signalling channel over the shared bus only
        st_nxt.line_en = cfg.line_if_active;

        // Serial port ignored in relay mode; the board ties chip select high
        // Relay boards run stand-alone, so the port stays shut
        st_nxt.spi_en = !cfg.side_channel_en && !spi_chip_select_n;

        // Strobe marks the codec slot where enabled
        // Relay mode keeps the strobe low
        st_nxt.strobe = cfg.strobe_en && strobe_slot;

        // Upstream access only when the shared bus is free; framer must not use the line
        // Last cycle's flags keep the grant clear of decode transients
        st_nxt.grant = (st_r.m_framer || st_r.m_relay) && bus_request && bus_free;

        // Count crystal rising edges after reset in framer mode
        // Only rising edges of the synchronised level count
        // Leaving framer mode clears both the count and the flag
        st_nxt.xtal_prev = sync_straps.crystal_input;
        if (!st_r.m_framer)
        begin
            st_nxt.xtal_cnt = oms_pkg::XCNT_ZERO;
            st_nxt.xdone    = 1'b0;
        end
        else if (!st_r.xdone && sync_straps.crystal_input && !st_r.xtal_prev)
        begin
            st_nxt.xtal_cnt = st_r.xtal_cnt + oms_pkg::XCNT_ONE;
            if (st_nxt.xtal_cnt == XTAL_TARGET)
            begin
                st_nxt.xdone = 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    // Reset leaves every pin undriven and the device in handset defaults off
    // Asynchronous clear, so outputs go quiet even without a running clock
    // The next clock loads the decode of the idle strap levels
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    // Pin drivers
    assign pulse_ring_mode_pin_out  = st_r.pr_out;
    assign pulse_ring_mode_pin_oe   = st_r.pr_oe;
    assign backplane_data_clock_out = st_r.dcl_out;
    assign backplane_data_clock_oe  = st_r.dcl_oe;

    // Mode flags
    assign handset_mode             = st_r.m_handset;
    assign relay_station_mode       = st_r.m_relay;
    assign framer_mode              = st_r.m_framer;

    // Configuration levels
    assign supply_detect_en         = st_r.sup_en;
    assign ext_reset_required       = st_r.ext_rst;
    assign test_reg_select_en       = st_r.test_en;
    assign side_channel_bit         = st_r.side_bit;
    assign line_if_enable           = st_r.line_en;

    // Gated same-clock results
    assign shared_access_bus_grant  = st_r.grant;
    assign serial_strobe            = st_r.strobe;
    assign spi_enable               = st_r.spi_en;

    // Framer reset status
    assign framer_reset_done        = st_r.xdone;

endmodule

// ### tb_operating_mode_strap_select.sv
// Testbench: strap decode, output gating and framer reset counting
`timescale 1ns/10ps
module tb_operating_mode_strap_select;
    logic        core_clk  = 1'h0;
    logic        rst       = 1'h1;
    logic [3:0]  strap_req = 4'hC;
    logic [6:0]  rin       = 7'h01;
    wire  [15:0] seen;
    logic [15:0] e;
    logic        sw, fp, rs, pin_in, xtal, cs_n;
    int          miscompares = 0;
    int          checked     = 0;
    int unsigned seed;

    always #50 core_clk = ~core_clk;

    oms_board board (.core_clk, .strap_req, .cs_req_n(rin[0]), .pin_drive(seen[15]), .pin_drive_oe(seen[14]),
        .supply_watch_select(sw), .factory_probe_pin(fp), .repeater_or_handset_select(rs),
        .pulse_ring_mode_pin_in(pin_in), .crystal_input(xtal), .spi_chip_select_n(cs_n));

    oms_top DUT (.core_clk, .rst, .supply_watch_select(sw), .factory_probe_pin(fp),
        .repeater_or_handset_select(rs), .pulse_ring_mode_pin_in(pin_in), .crystal_input(xtal),
        .stop_go_bit(rin[6]), .pulse_ring_value(rin[5]), .strobe_slot(rin[4]), .local_data_clock(rin[3]),
        .spi_chip_select_n(cs_n), .bus_request(rin[2]), .bus_free(rin[1]),
        .pulse_ring_mode_pin_out(seen[15]), .pulse_ring_mode_pin_oe(seen[14]),
        .backplane_data_clock_out(seen[13]), .backplane_data_clock_oe(seen[12]), .handset_mode(seen[11]),
        .relay_station_mode(seen[10]), .framer_mode(seen[9]), .supply_detect_en(seen[8]),
        .ext_reset_required(seen[7]), .test_reg_select_en(seen[6]), .side_channel_bit(seen[5]),
        .line_if_enable(seen[4]), .shared_access_bus_grant(seen[3]), .serial_strobe(seen[2]),
        .spi_enable(seen[1]), .framer_reset_done(seen[0]));

    // Expected outputs from straps {watch, probe, select, pin} and same-clock inputs
    function automatic logic [15:0] expect_out(input logic [3:0] s, input logic [6:0] i);
        logic w, h, r, f, cs;
        w  = s[3];
        h  = !s[1];
        r  = s[1] && !s[0];
        f  = s[1] && s[0];
        cs = r ? 1'h1 : i[0];
        return {h & i[5], h, h & i[3], h, h, r, f, !w & !r, w & !r, !s[2],
                r ? (w | i[6]) : 1'h1, !f, (r | f) & i[2] & i[1], (h | f) & i[4], !r & !cs, 1'h0};
    endfunction

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Bounded wait for n crystal rising edges; a hang counts as a mismatch
    task automatic wait_xtal(input int n);
        int   cnt;
        logic prev;
        cnt  = 0;
        prev = xtal;
        for (int t = 0; t < 1000 && cnt < n; t++)
        begin
            @(posedge core_clk);
            if (xtal && !prev)
                cnt++;
            prev = xtal;
        end
        if (cnt < n)
        begin
            miscompares++;
            results();
        end
        #1;
    endtask

    initial
    begin
        seed = $urandom(51);
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        // Every mode with both watch and probe levels; corners then random inputs
        for (int m = 0; m < 12; m++)
        begin
            @(posedge core_clk);
            strap_req <= {m[0], m[1], m >= 4, m >= 8};
            repeat (8) @(posedge core_clk);
            for (int k = 0; k < 6; k++)
            begin
                @(posedge core_clk);
                rin <= (k == 0) ? 7'h7F : (k == 1) ? 7'h00 : 7'($urandom);
                repeat (2) @(posedge core_clk);
                #1;
                e = expect_out(strap_req, rin);
                check("outputs", seen & 16'hFFFE, e & 16'hFFFE);
            end
        end
        // Second reset with framer straps held; crystal keeps running through it
        @(posedge core_clk);
        strap_req <= 4'hF;
        rst       <= 1'h1;
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        wait_xtal(77);
        check("reset_done_early", {15'h0, seen[0]}, 16'h0000);
        wait_xtal(7);
        check("reset_done", {15'h0, seen[0]}, 16'h0001);
        // Leaving framer mode drops the done flag
        @(posedge core_clk);
        strap_req <= 4'hC;
        repeat (8) @(posedge core_clk);
        #1;
        check("reset_done_clear", {15'h0, seen[0]}, 16'h0000);
        results();
    end
endmodule
